// >>> core/swc_pkg.sv
package swc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, 8-bit data in the low lane)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_RESET_CTRL = 12'h000;
  localparam logic [11:0] OFS_RESET_CTRL_TWO = 12'h004;
  localparam logic [11:0] OFS_RESET_CTRL_FOUR = 12'h008;
  localparam logic [11:0] OFS_DS_CTRL_HIGH = 12'h00c;
  localparam logic [11:0] OFS_WAKE_SRC_LOW = 12'h010;
  localparam logic [11:0] OFS_WAKE_SRC_HIGH = 12'h014;
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h018;
  localparam logic [11:0] OFS_STATUS = 12'h01c;
  localparam logic [11:0] OFS_CONTEXT_BASE = 12'h020;

  // Field positions
  localparam int BIT_IRQ_PRIO_EN = 7;
  localparam int BIT_WDT_WAKE = 5;
  localparam int BIT_RET_SW_EN = 4;
  localparam int BIT_DS_EXIT = 2;
  localparam int BIT_DS_ARM = 7;
  localparam int BIT_WK_MASTER_CLEAR_PIN = 0;
  localparam int BIT_WK_POR = 1;
  localparam int BIT_WK_RTC = 2;
  localparam int BIT_WK_DEEP_SLEEP_WATCHDOG = 3;
  localparam int BIT_WK_DEEP_SLEEP_BROWNOUT = 6;
  localparam int BIT_WK_EXT0 = 0;

  // Reset values
  localparam logic [7:0] RST_REG8 = 8'h00;
  localparam logic [1:0] ARM_WRITES = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int PM_SETTLE_NS = 10000;
  localparam int RET_STARTUP_NS = 20000;
  localparam int PLL_LOCK_NS = 2000;
  localparam int FAST_RC_NS = 1000;
  localparam int SLOW_RC_NS = 5000;
  localparam int POR_HOLD_NS = 1000;
  localparam logic [12:0] PM_CYC = 13'((PM_SETTLE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [12:0] RET_CYC = 13'((RET_STARTUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [12:0] LOCK_CYC = 13'((PLL_LOCK_NS * CLK_MHZ + 999) / 1000);
  localparam logic [12:0] FRC_CYC = 13'((FAST_RC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [12:0] SRC_CYC = 13'((SLOW_RC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [12:0] POR_CYC = 13'((POR_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [12:0] OST_PERIODS = 13'h0400;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_EXT, OSC_EXT_PLL, OSC_XTAL, OSC_XTAL_PLL,
    OSC_SEC, OSC_FRC, OSC_FRC_PLL, OSC_SLOW_RC
  } swc_osc_t;

  typedef enum logic [3:0] {
    ST_RUN, ST_SLEEP, ST_RSLEEP, ST_DSLEEP, ST_RDSLEEP,
    ST_RET, ST_PM, ST_OST, ST_LOCK, ST_RC, ST_POR
  } swc_state_t;

  typedef enum logic [1:0] {K_NEXT, K_VEC, K_RESET} swc_kind_t;

  typedef struct packed {
    logic master_clear_pin;
    logic por;
    logic rtcAlarm;
    logic extIrqZero;
    logic deep_sleep_watchdog;
    logic dsBrownout;
  } swc_wake_t;

endpackage : swc_pkg

// >>> core/swc_sleep_wake_controller.sv
`timescale 1ns/1ps
`default_nettype none

module swc_sleep_wake_controller
  import swc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepExec,
  input wire logic [7:0] irqPending,
  input wire logic globalIrqEnable,
  input wire logic wdtEnable,
  input wire logic wdtExpire,
  input wire logic devReset,
  input wire swc_wake_t wake,
  input wire swc_osc_t oscMode,
  input wire swc_osc_t defaultOsc,
  input wire logic oscRanInSleep,
  input wire logic oscTick,
  input wire logic retentionCfgN,
  input wire logic rtcEnable,
  output logic coreRun,
  output logic irqVectorGo,
  output logic resumeNext,
  output logic resetVectorGo,
  output logic sysPor,
  output logic mainRegOn,
  output logic retRegOn,
  output logic dsMonEn,
  output logic stdMonEn,
  output logic rtcRun,
  output swc_osc_t clkSrc
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  swc_state_t state_q, state_d;
  swc_kind_t kind_q;
  swc_osc_t clkSrc_q;
  logic [12:0] cnt_q;
  logic [7:0] resetCtrl_q, irqEn_q, wakeLow_q, wakeHigh_q;
  logic [7:0] ctx_q [4];
  logic wdtFlag_q, retSwEn_q, dsExit_q, heldIrq_q, pready_q, pslverr_q;
  logic [1:0] armCnt_q;
  logic [31:0] prdata_q;
  logic coreRun_q, irqVectorGo_q, resumeNext_q, resetVectorGo_q;
  logic sysPor_q, mainRegOn_q, retRegOn_q, dsMonEn_q, stdMonEn_q, rtcRun_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire setupPh = psel & ~penable;
  wire wrEn = psel & penable & pwrite & pready_q;
  wire selRc = paddr == OFS_RESET_CTRL;
  wire selRc2 = paddr == OFS_RESET_CTRL_TWO;
  wire selRc4 = paddr == OFS_RESET_CTRL_FOUR;
  wire selDsh = paddr == OFS_DS_CTRL_HIGH;
  wire selWl = paddr == OFS_WAKE_SRC_LOW;
  wire selWh = paddr == OFS_WAKE_SRC_HIGH;
  wire selIe = paddr == OFS_IRQ_ENABLE;
  wire selSt = paddr == OFS_STATUS;
  wire selCtx = paddr[11:4] == OFS_CONTEXT_BASE[11:4] && paddr[1:0] == 2'h0;
  wire mapped = selRc | selRc2 | selRc4 | selDsh | selWl | selWh | selIe
                | selSt | selCtx;
  wire [7:0] wrByte = pwdata[7:0];
  wire irq_priority_enable = resetCtrl_q[BIT_IRQ_PRIO_EN];
  wire armOn = armCnt_q == ARM_WRITES;
  wire retEff = ~retentionCfgN & retSwEn_q;
  wire irqWake = |(irqPending & irqEn_q) | heldIrq_q;
  wire wdtWake = wdtEnable & wdtExpire;
  wire sleepWake = irqWake | wdtWake | devReset;
  wire dsWake = wake.master_clear_pin | wake.por | wake.rtcAlarm | wake.extIrqZero
                | wake.deep_sleep_watchdog;
  wire inSleep = state_q == ST_SLEEP || state_q == ST_RSLEEP;
  wire inDeep = state_q == ST_DSLEEP || state_q == ST_RDSLEEP;
  wire enterDeep = state_q == ST_RUN && sleepExec && armOn;

  // ----------------------------------------------------------------
  // Delay counter
  // ----------------------------------------------------------------
  logic [12:0] tgt;
  always_comb begin
    case (state_q)
      ST_RET: tgt = RET_CYC - 13'd1;
      ST_PM: tgt = PM_CYC - 13'd1;
      ST_OST: tgt = OST_PERIODS - 13'd1;
      ST_LOCK: tgt = LOCK_CYC - 13'd1;
      ST_RC: tgt = (clkSrc_q == OSC_SLOW_RC) ? SRC_CYC - 13'd1 : FRC_CYC - 13'd1;
      ST_POR: tgt = POR_CYC - 13'd1;
      default: tgt = 13'd0;
    endcase
  end
  // The start-up timer runs on the starting oscillator, not on clk
  wire adv = (state_q == ST_OST) ? oscTick : 1'b1;
  wire cntDone = adv && cnt_q == tgt;

  // Oscillator delay that follows the exit delay
  function automatic swc_state_t oscFirst(swc_osc_t m, logic ran);
    case (m)
      OSC_EXT: oscFirst = ST_RUN;
      OSC_EXT_PLL, OSC_FRC_PLL: oscFirst = ST_LOCK;
      OSC_XTAL, OSC_XTAL_PLL, OSC_SEC: oscFirst = ST_OST;
      OSC_FRC, OSC_SLOW_RC: oscFirst = ST_RC;
      default: oscFirst = ST_RUN;
    endcase
    // A source kept running through sleep needs no start-up delay
    if (ran) oscFirst = ST_RUN;
  endfunction : oscFirst
  wire swc_state_t oscNext = oscFirst(clkSrc_q, oscRanInSleep);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (sleepExec) begin
          if (armOn) begin
            state_d = retEff ? ST_RDSLEEP : ST_DSLEEP;
          end else begin
            state_d = retEff ? ST_RSLEEP : ST_SLEEP;
          end
        end
      end
      ST_SLEEP: if (sleepWake) state_d = ST_PM;
      ST_RSLEEP: if (sleepWake) state_d = ST_RET;
      ST_DSLEEP: if (dsWake) state_d = ST_POR;
      ST_RDSLEEP: if (dsWake) state_d = ST_RET;
      ST_RET: if (cntDone) state_d = irq_priority_enable ? oscNext : ST_PM;
      ST_PM: if (cntDone) state_d = oscNext;
      ST_OST: if (cntDone) state_d = (clkSrc_q == OSC_XTAL_PLL) ? ST_LOCK : ST_RUN;
      ST_LOCK, ST_RC, ST_POR: if (cntDone) state_d = ST_RUN;
      default: state_d = ST_RUN;
    endcase
  end

  wire leaving = state_q != state_d;
  wire finish = state_q != ST_RUN && state_d == ST_RUN;
  wire isDeep = state_d == ST_DSLEEP || state_d == ST_RDSLEEP;
  wire isRet = state_d == ST_RSLEEP || state_d == ST_RDSLEEP
               || state_d == ST_RET;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_RUN;
      cnt_q <= 13'd0;
      kind_q <= K_NEXT;
      clkSrc_q <= OSC_EXT;
      heldIrq_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      if (leaving) cnt_q <= 13'd0;
      else if (adv && cnt_q != tgt) cnt_q <= cnt_q + 13'd1;
      if (state_q == ST_RUN && sleepExec) clkSrc_q <= oscMode;
      if (state_d == ST_POR && leaving) clkSrc_q <= defaultOsc;
      if (state_q == ST_RUN && sleepExec && !armOn) begin
        heldIrq_q <= |(irqPending & irqEn_q);
      end else if (inSleep && leaving) begin
        heldIrq_q <= 1'b0;
      end
      if (inSleep && sleepWake) begin
        if (devReset) kind_q <= K_RESET;
        else if (irqWake && globalIrqEnable) kind_q <= K_VEC;
        else kind_q <= K_NEXT;
      end
      if (state_q == ST_DSLEEP && dsWake) kind_q <= K_RESET;
      if (state_q == ST_RDSLEEP && dsWake) kind_q <= K_NEXT;
    end
  end

  // ----------------------------------------------------------------
  // Power, clock and resume outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      coreRun_q <= 1'b1;
      irqVectorGo_q <= 1'b0;
      resumeNext_q <= 1'b0;
      resetVectorGo_q <= 1'b0;
      sysPor_q <= 1'b0;
      mainRegOn_q <= 1'b1;
      retRegOn_q <= 1'b0;
      dsMonEn_q <= 1'b0;
      stdMonEn_q <= 1'b1;
      rtcRun_q <= 1'b0;
    end else if (ce) begin
      coreRun_q <= state_d == ST_RUN;
      irqVectorGo_q <= finish && kind_q == K_VEC;
      resumeNext_q <= finish && kind_q == K_NEXT;
      resetVectorGo_q <= finish && kind_q == K_RESET;
      sysPor_q <= state_d == ST_POR;
      mainRegOn_q <= !(state_d inside {ST_SLEEP, ST_RSLEEP, ST_DSLEEP, ST_RDSLEEP, ST_RET});
      retRegOn_q <= isRet & retEff;
      dsMonEn_q <= isDeep;
      stdMonEn_q <= !isDeep;
      rtcRun_q <= rtcEnable;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  wire wakeSetLow = inDeep;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      resetCtrl_q <= RST_REG8;
      irqEn_q <= RST_REG8;
      wakeLow_q <= RST_REG8;
      wakeHigh_q <= RST_REG8;
      wdtFlag_q <= 1'b0;
      retSwEn_q <= 1'b0;
      dsExit_q <= 1'b0;
      armCnt_q <= 2'h0;
      for (int i = 0; i < 4; i++) ctx_q[i] <= RST_REG8;
    end else if (ce) begin
      if (wrEn && selRc) resetCtrl_q <= wrByte;
      if (state_d == ST_POR && leaving) irqEn_q <= RST_REG8;
      else if (wrEn && selIe) irqEn_q <= wrByte;
      if (wrEn && selRc4) retSwEn_q <= wrByte[BIT_RET_SW_EN];
      // Hardware set wins over a software clear in the same cycle
      if (inSleep && wdtWake && !irqWake && !devReset) wdtFlag_q <= 1'b1;
      else if (wrEn && selRc2 && !wrByte[BIT_WDT_WAKE]) wdtFlag_q <= 1'b0;
      if (state_d == ST_POR && leaving) dsExit_q <= 1'b1;
      else if (wrEn && selRc4 && !wrByte[BIT_DS_EXIT]) dsExit_q <= 1'b0;
      if (enterDeep) begin
        armCnt_q <= 2'h0;
      end else if (wrEn && selDsh) begin
        if (!wrByte[BIT_DS_ARM]) armCnt_q <= 2'h0;
        else if (!armOn) armCnt_q <= armCnt_q + 2'h1;
      end
      if (enterDeep) begin
        wakeLow_q <= RST_REG8;
        wakeHigh_q <= RST_REG8;
      end else if (wakeSetLow) begin
        wakeLow_q[BIT_WK_MASTER_CLEAR_PIN] <= wakeLow_q[BIT_WK_MASTER_CLEAR_PIN] | wake.master_clear_pin;
        wakeLow_q[BIT_WK_POR] <= wakeLow_q[BIT_WK_POR] | wake.por;
        wakeLow_q[BIT_WK_RTC] <= wakeLow_q[BIT_WK_RTC] | wake.rtcAlarm;
        wakeLow_q[BIT_WK_DEEP_SLEEP_WATCHDOG] <= wakeLow_q[BIT_WK_DEEP_SLEEP_WATCHDOG] | wake.deep_sleep_watchdog;
        wakeLow_q[BIT_WK_DEEP_SLEEP_BROWNOUT] <= wakeLow_q[BIT_WK_DEEP_SLEEP_BROWNOUT] | wake.dsBrownout;
        wakeHigh_q[BIT_WK_EXT0] <= wakeHigh_q[BIT_WK_EXT0] | wake.extIrqZero;
      end
      // Context words are untouched by the internal reset on wake
      if (wrEn && selCtx) ctx_q[paddr[3:2]] <= wrByte;
    end
  end

  // ----------------------------------------------------------------
  // APB read path, zero wait state
  // ----------------------------------------------------------------
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    if (selRc) rdByte = resetCtrl_q;
    if (selRc2) rdByte[BIT_WDT_WAKE] = wdtFlag_q;
    if (selRc4) begin
      rdByte[BIT_RET_SW_EN] = retSwEn_q;
      rdByte[BIT_DS_EXIT] = dsExit_q;
    end
    if (selDsh) rdByte[BIT_DS_ARM] = armOn;
    if (selWl) rdByte = wakeLow_q;
    if (selWh) rdByte = wakeHigh_q;
    if (selIe) rdByte = irqEn_q;
    if (selSt) rdByte = {1'b0, clkSrc_q, state_q};
    if (selCtx) rdByte = ctx_q[paddr[3:2]];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= setupPh;
      pslverr_q <= setupPh & ~mapped;
      if (setupPh) prdata_q <= {24'h00_0000, rdByte};
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign coreRun = coreRun_q;
  assign irqVectorGo = irqVectorGo_q;
  assign resumeNext = resumeNext_q;
  assign resetVectorGo = resetVectorGo_q;
  assign sysPor = sysPor_q;
  assign mainRegOn = mainRegOn_q;
  assign retRegOn = retRegOn_q;
  assign dsMonEn = dsMonEn_q;
  assign stdMonEn = stdMonEn_q;
  assign rtcRun = rtcRun_q;
  assign clkSrc = clkSrc_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_core_gated;
    @(posedge clk) disable iff (!resetn) coreRun_q |-> state_q == ST_RUN;
  endproperty
  a_core_gated: assert property (p_core_gated) else $error("core clock on off run");
  property p_wdt_flag;
    @(posedge clk) disable iff (!resetn)
      ce && inSleep && wdtWake && !irqWake && !devReset |=> wdtFlag_q;
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("watchdog wake flag not set");
  property p_wake_clear;
    @(posedge clk) disable iff (!resetn)
      ce && enterDeep |=> wakeLow_q == 8'h00 && wakeHigh_q == 8'h00;
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake sources not cleared");
  property p_pm_len;
    @(posedge clk) disable iff (!resetn)
      $past(state_q) == ST_PM && state_q != ST_PM |-> $past(cnt_q) == PM_CYC - 13'd1;
  endproperty
  a_pm_len: assert property (p_pm_len) else $error("settle delay wrong length");
  property p_ost_len;
    @(posedge clk) disable iff (!resetn)
      $past(state_q) == ST_OST && state_q != ST_OST
      |-> $past(cnt_q) == OST_PERIODS - 13'd1 && $past(oscTick);
  endproperty
  a_ost_len: assert property (p_ost_len) else $error("start-up timer wrong length");
  property p_ret_pm;
    @(posedge clk) disable iff (!resetn)
      $past(state_q) == ST_RET && state_q == ST_PM |-> !$past(irq_priority_enable);
  endproperty
  a_ret_pm: assert property (p_ret_pm) else $error("settle delay with priority on");
  property p_arm_two;
    @(posedge clk) disable iff (!resetn)
      ce && state_q == ST_RUN && sleepExec && armCnt_q != ARM_WRITES |=> !inDeep;
  endproperty
  a_arm_two: assert property (p_arm_two) else $error("deep sleep without two writes");
  property p_ret_reg;
    @(posedge clk) disable iff (!resetn)
      state_q == ST_RSLEEP |-> retRegOn_q && !mainRegOn_q;
  endproperty
  a_ret_reg: assert property (p_ret_reg) else $error("retention regulator state wrong");
  property p_por_flag;
    @(posedge clk) disable iff (!resetn)
      state_q == ST_POR |-> dsExit_q && sysPor_q;
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("deep sleep exit not flagged");
  property p_ds_only;
    @(posedge clk) disable iff (!resetn)
      ce && inDeep && !dsWake |=> state_q == $past(state_q);
  endproperty
  a_ds_only: assert property (p_ds_only) else $error("deep sleep left without source");

  c_rsleep: cover property (@(posedge clk) disable iff (!resetn) state_q == ST_RSLEEP);
  c_por: cover property (@(posedge clk) disable iff (!resetn) state_q == ST_POR);
  c_ost: cover property (@(posedge clk) disable iff (!resetn) state_q == ST_OST);
  c_rdeep: cover property (@(posedge clk) disable iff (!resetn) state_q == ST_RDSLEEP);

endmodule : swc_sleep_wake_controller

`default_nettype wire

// >>> dv/swc_osc_model.sv
`timescale 1ns/1ps
`default_nettype none

// Starting oscillator seen from the core clock: one tick per period.
// Free-running, since a restarting crystal has no phase tie to clk.
module swc_osc_model #(
  parameter int TICK = 2
) (
  input wire logic clk,
  input wire logic resetn,
  output logic oscTick
);
  int cnt;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      oscTick <= 1'b0;
    end else begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      oscTick <= (cnt == TICK - 1);
    end
  end
endmodule : swc_osc_model

`default_nettype wire

// >>> dv/swc_sleep_wake_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none

module swc_sleep_wake_controller_bench
  import swc_pkg::*;
;
  localparam int TICK = 2;
  logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sleepExec = 1'b0, globalIrqEnable = 1'b0, wdtEnable = 1'b1;
  logic wdtExpire = 1'b0, devReset = 1'b0, oscRanInSleep = 1'b0;
  logic retentionCfgN = 1'b1, rtcEnable = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [7:0] irqPending = 8'h00;
  swc_wake_t wake = '0;
  swc_osc_t oscMode = OSC_EXT, defaultOsc = OSC_FRC, clkSrc;
  logic pready, pslverr, oscTick, coreRun, irqVectorGo, resumeNext, resetVectorGo;
  logic sysPor, mainRegOn, retRegOn, dsMonEn, stdMonEn, rtcRun;
  logic [2:0] ep [4] = '{3'b100, 3'b010, 3'b010, 3'b001};
  int cyc = 0, checks = 0, miscompares = 0;

  swc_sleep_wake_controller uut (
    .clk, .resetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .sleepExec, .irqPending, .globalIrqEnable, .wdtEnable,
    .wdtExpire, .devReset, .wake, .oscMode, .defaultOsc, .oscRanInSleep, .oscTick,
    .retentionCfgN, .rtcEnable, .coreRun, .irqVectorGo, .resumeNext, .resetVectorGo,
    .sysPor, .mainRegOn, .retRegOn, .dsMonEn, .stdMonEn, .rtcRun, .clkSrc
  );
  swc_osc_model #(.TICK(TICK)) osc (.clk, .resetn, .oscTick);

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic rng(input string nm, input int e, input int n);
    checks++;
    if (n < e || n > e + 8) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, n);
    end
  endtask : rng

  function automatic int exp_delay(swc_osc_t m, logic ran, logic ret, logic irq_priority_enable);
    int d;
    int o;
    d = ret ? RET_CYC + (irq_priority_enable ? 0 : PM_CYC) : PM_CYC;
    case (m)
      OSC_EXT_PLL, OSC_FRC_PLL: o = LOCK_CYC;
      OSC_XTAL, OSC_SEC: o = 1024 * TICK;
      OSC_XTAL_PLL: o = 1024 * TICK + LOCK_CYC;
      OSC_FRC: o = FRC_CYC;
      OSC_SLOW_RC: o = SRC_CYC;
      default: o = 0;
    endcase
    return ran ? d : d + o;
  endfunction : exp_delay

  // Ends one idle cycle after release so back-to-back calls never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No local wait limit: the bench's cycle ceiling ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(nm, x, r);
  endtask : rdc

  // Sleeps, optionally shows non-sources first, then wakes and times it
  task automatic doze(input logic [7:0] irq, input logic wdt, input logic dev,
      input swc_wake_t wk, input logic nz, output int n, output logic [2:0] pl,
      output logic [5:0] st, output logic por);
    sleepExec <= 1'b1;
    @(posedge clk);
    sleepExec <= 1'b0;
    repeat (3) @(posedge clk);
    st = {coreRun, mainRegOn, retRegOn, dsMonEn, stdMonEn, rtcRun};
    if (nz) begin
      irqPending <= 8'hff;
      wdtExpire <= 1'b1;
      repeat (20) @(posedge clk);
      chk("deep_hold", 0, coreRun);
    end
    irqPending <= irq;
    wdtExpire <= wdt;
    devReset <= dev;
    wake <= wk;
    n = 0;
    por = 1'b0;
    do begin
      @(posedge clk);
      n++;
      por = por | sysPor;
    end while (coreRun !== 1'b1 && n < 20000);
    pl = {irqVectorGo, resumeNext, resetVectorGo};
    irqPending <= 8'h00;
    wdtExpire <= 1'b0;
    devReset <= 1'b0;
    wake <= '0;
    @(posedge clk);
  endtask : doze

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    int n;
    logic [2:0] pl;
    logic [5:0] st;
    logic por, e;
    logic [31:0] r;
    logic [31:0] ctx [4];
    swc_osc_t m;
    void'($urandom(32'h2259f3d4));
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("reset_outs", 6'b111000, {coreRun, mainRegOn, stdMonEn, retRegOn, dsMonEn, sysPor});
    chk("reset_clk", OSC_EXT, clkSrc);
    apb(1'b0, 12'h100, 32'h0, r, e);
    chk("unmapped_err", 1, e);
    wr(OFS_IRQ_ENABLE, 32'hff);
    for (int i = 0; i < 4; i++) begin
      ctx[i] = {24'h0, 8'($urandom)};
      wr(OFS_CONTEXT_BASE + 12'(4 * i), ctx[i]);
    end
    $display("test regs done");
    for (int k = 0; k < 4; k++) begin
      globalIrqEnable <= (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : 1'($urandom);
      doze(k < 2 ? 8'h01 << $urandom_range(7) : 8'h00, k == 2, k == 3, '0, 1'b0,
           n, pl, st, por);
      rng("wake_delay", exp_delay(OSC_EXT, 1'b0, 1'b0, 1'b0), n);
      chk("wake_kind", ep[k], pl);
      chk("sleep_state", 6'b000011, st);
      if (k == 2) begin
        rdc("wdt_flag", OFS_RESET_CTRL_TWO, 32'h20);
        wr(OFS_RESET_CTRL_TWO, 32'h0);
      end
    end
    $display("test wake kinds done");
    globalIrqEnable <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      m = swc_osc_t'(i < 8 ? i : 3);
      oscMode <= m;
      oscRanInSleep <= (i == 8);
      doze(8'h80, 1'b0, 1'b0, '0, 1'b0, n, pl, st, por);
      rng("osc_delay", exp_delay(m, i == 8, 1'b0, 1'b0), n);
      chk("osc_restart", m, clkSrc);
    end
    oscMode <= OSC_EXT;
    oscRanInSleep <= 1'b0;
    $display("test oscillators done");
    for (int j = 0; j < 3; j++) begin
      retentionCfgN <= (j == 2);
      wr(OFS_RESET_CTRL_FOUR, 32'h10);
      wr(OFS_RESET_CTRL, j == 1 ? 32'h80 : 32'h0);
      doze(8'h01 << $urandom_range(7), 1'b0, 1'b0, '0, 1'b0, n, pl, st, por);
      chk("ret_state", j < 2 ? 6'b001011 : 6'b000011, st);
      rng("ret_delay", exp_delay(OSC_EXT, 1'b0, j < 2, j == 1), n);
    end
    wr(OFS_RESET_CTRL_FOUR, 32'h0);
    wr(OFS_RESET_CTRL, 32'h0);
    $display("test retention done");
    // Interrupt raised only with the sleep instruction, then dropped
    fork
      doze(8'h00, 1'b0, 1'b0, '0, 1'b0, n, pl, st, por);
      begin
        irqPending <= 8'h04;
        @(posedge clk);
        irqPending <= 8'h00;
      end
    join
    chk("held_irq", 4'b1010, {n < PM_CYC, pl});
    $display("test held interrupt done");
    wr(OFS_DS_CTRL_HIGH, 32'h80);
    rdc("arm_once", OFS_DS_CTRL_HIGH, 32'h0);
    doze(8'h02, 1'b0, 1'b0, '0, 1'b0, n, pl, st, por);
    chk("unarmed", {1'b0, 3'b010, 6'b000011}, {por, pl, st});
    wr(OFS_DS_CTRL_HIGH, 32'h0);
    $display("test unarmed done");
    oscMode <= OSC_XTAL;
    for (int t = 0; t < 2; t++) begin
      wr(OFS_DS_CTRL_HIGH, 32'h80);
      wr(OFS_DS_CTRL_HIGH, 32'h80);
      doze(8'h00, 1'b0, 1'b0, t == 0 ? 6'b001000 : 6'b000100, 1'b1, n, pl, st, por);
      chk("deep_exit", {1'b1, 3'b001, 6'b000101}, {por, pl, st});
      rng("deep_delay", POR_CYC, n);
      chk("deep_clk", defaultOsc, clkSrc);
      rdc("wake_low", OFS_WAKE_SRC_LOW, t == 0 ? 32'h04 : 32'h0);
      rdc("wake_high", OFS_WAKE_SRC_HIGH, t);
    end
    rdc("status", OFS_STATUS, {25'h0, defaultOsc, 4'h0});
    rdc("ds_flag", OFS_RESET_CTRL_FOUR, 32'h04);
    wr(OFS_RESET_CTRL_FOUR, 32'h0);
    rdc("ds_flag_clr", OFS_RESET_CTRL_FOUR, 32'h0);
    rdc("irq_en_por", OFS_IRQ_ENABLE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rdc("context", OFS_CONTEXT_BASE + 12'(4 * i), ctx[i]);
    end
    $display("test deep sleep done");
    retentionCfgN <= 1'b0;
    oscMode <= OSC_EXT;
    wr(OFS_RESET_CTRL_FOUR, 32'h10);
    wr(OFS_DS_CTRL_HIGH, 32'h80);
    wr(OFS_DS_CTRL_HIGH, 32'h80);
    doze(8'h00, 1'b0, 1'b0, 6'b000100, 1'b1, n, pl, st, por);
    chk("rdeep_exit", {1'b0, 3'b010, 6'b001101}, {por, pl, st});
    rng("rdeep_delay", exp_delay(OSC_EXT, 1'b0, 1'b1, 1'b0), n);
    $display("test retention deep done");
    close_out();
  end
endmodule : swc_sleep_wake_controller_bench

`default_nettype wire
